// *** design/ddr_burst_sram_map.vh ***
// constants shared by the burst sram port design files
`ifndef DDR_BURST_SRAM_MAP_VH
`define DDR_BURST_SRAM_MAP_VH
// words per burst and beat counter
`define BURST_LEN 4
`define BURST_CNT_W 2
`define BEAT_FIRST 2'h0
`define BEAT_SECOND 2'h1
`define BEAT_LAST 2'h3
// word address width per variant
`define ADDR_W_NARROW 20
`define ADDR_W_X18 19
`define ADDR_W_X36 18
// data width and lane layout per variant
`define DATA_W_X8 8
`define DATA_W_X18 18
`define DATA_W_X36 36
`define LANES_X8 2
`define LANES_X18 2
`define LANES_X36 4
`define NIBBLE_W 4
`define BYTE_LANE_W 9
// output buffer depth
`define SKID_DEPTH 2
// reset values of output state
`define OE_RESET 1'b0
`define STROBE_RESET 1'b0
`endif

// *** design/burst_word_mem.v ***
// one burst-word array with lane-masked writes and a registered read
`timescale 1ns/100ps
module burst_word_mem
#(
   parameter AW = 18,
   parameter DW = 36,
   parameter NL = 4
)
(
   input wire core_clk,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [NL-1:0] wr_lane,
   input wire [DW-1:0] wr_data,
   input wire rd_en,
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data
);
   localparam LW = DW / NL; // lane width
   reg [DW-1:0] mem [0:(1<<AW)-1]; // array storage, no reset
   integer i;
   // ---------------------------------------------
   // write only the enabled lanes, others keep
   // ---------------------------------------------
   always @(posedge core_clk)
   begin
      if (wr_en)
      begin
         for (i = 0; i < NL; i = i + 1)
         begin
            if (wr_lane[i])
               mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
         end
      end
   end
   // read data leave through a register
   always @(posedge core_clk)
   begin
      if (rd_en)
         rd_data <= mem[rd_addr];
   end
endmodule

// *** design/read_skid_buffer.v ***
// small fifo in the read data path, valid and ready on both sides
`timescale 1ns/100ps
module read_skid_buffer
#(
   parameter WIDTH = 36,
   parameter DEPTH = 2,
   parameter PW = 1
)
(
   input wire core_clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] slot_q [0:DEPTH-1]; // entries
   reg [PW-1:0] wp_q; // write pointer
   reg [PW-1:0] rp_q; // read pointer
   reg [PW:0] cnt_q; // fill level
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[PW:0]);
   assign out_valid = (cnt_q != {(PW+1){1'b0}});
   assign out_data = slot_q[rp_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   // ---------------------------------------------
   // pointers wrap at depth, count tracks fill
   // ---------------------------------------------
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_q <= {PW{1'b0}};
         rp_q <= {PW{1'b0}};
         cnt_q <= {(PW+1){1'b0}};
      end
      else
      begin
         if (push)
            wp_q <= (wp_q == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} :
                    wp_q + 1'b1;
         if (pop)
            rp_q <= (rp_q == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} :
                    rp_q + 1'b1;
         if (push & ~pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop & ~push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
   // entry storage, written on push only
   always @(posedge core_clk)
   begin
      if (push)
         slot_q[wp_q] <= in_data;
   end
endmodule

// *** design/ddr_burst_sram_port.v ***
// device side of a burst sram with separate ddr read and write ports
`timescale 1ns/100ps
`include "ddr_burst_sram_map.vh"
module ddr_burst_sram_port
#(
   parameter ADDR_W = `ADDR_W_X36,
   parameter DATA_W = `DATA_W_X36,
   parameter LANES = `LANES_X36
)
(
   input wire core_clk,
   input wire rst_n,
   input wire k_rise,
   input wire [ADDR_W-1:0] addr,
   input wire read_port_sel_n,
   input wire write_port_sel_n,
   input wire [DATA_W-1:0] write_data,
   input wire [LANES-1:0] byte_lane_enable_n,
   input wire single_clock_mode,
   input wire out_clk_edge,
   output wire [DATA_W-1:0] read_data_out,
   output wire read_data_oe,
   output wire return_strobe
);
   // ------------------------------------------------------------
   // local constants
   // ------------------------------------------------------------
   // read sequencer states
   localparam RD_IDLE = 2'h0;
   localparam RD_FETCH = 2'h1;
   localparam RD_SEND = 2'h2;
   // width of one lane (nibble or 9-bit byte)
   localparam LANE_W = DATA_W / LANES;
   localparam CW = `BURST_CNT_W;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // one-hot select of the array that owns a burst word
   function [`BURST_LEN-1:0] beat_onehot;
      input [CW-1:0] idx;
      begin
         beat_onehot = {{(`BURST_LEN-1){1'b0}}, 1'b1} << idx;
      end
   endfunction

   // pick one burst word out of the four array outputs
   function [DATA_W-1:0] pick_word;
      input [`BURST_LEN*DATA_W-1:0] words;
      input [CW-1:0] idx;
      begin
         pick_word = words[idx*DATA_W +: DATA_W];
      end
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   // write burst state
   reg wr_act_q; // write burst running
   reg wr_act_d;
   reg [CW-1:0] wr_beat_q; // next beat of the burst
   reg [CW-1:0] wr_beat_d;
   reg [ADDR_W-1:0] wr_addr_q; // held write address
   reg [ADDR_W-1:0] wr_addr_d;
   // read request state
   reg rd_pend_q; // read accepted, not fetched yet
   reg rd_pend_d;
   reg [ADDR_W-1:0] rd_addr_q; // held read address
   reg [ADDR_W-1:0] rd_addr_d;
   reg [1:0] rd_st_q; // read sequencer state
   reg [1:0] rd_st_d;
   reg [CW-1:0] rd_beat_q; // word being pushed
   reg [CW-1:0] rd_beat_d;
   // output stage
   reg [DATA_W-1:0] dout_q; // launched read word
   reg [DATA_W-1:0] dout_d;
   reg oe_q; // outputs driven
   reg oe_d;
   reg strobe_q; // return strobe level
   reg strobe_d;
   // array ports
   wire wr_start; // write burst starts this edge
   wire rd_start; // read requested this edge
   reg [`BURST_LEN-1:0] arr_we; // per-array write enable
   reg [ADDR_W-1:0] arr_waddr; // array write address
   wire [LANES-1:0] lane_mask; // lanes to store
   reg arr_re; // fetch all four words
   wire [`BURST_LEN*DATA_W-1:0] arr_rdata; // four fetched words
   // buffer ports
   reg buf_in_valid;
   wire buf_in_ready;
   wire [DATA_W-1:0] buf_in_data;
   wire buf_out_valid;
   wire [DATA_W-1:0] buf_out_data;
   wire launch; // a read data launch edge

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   // selects are looked at only on true edges
   assign wr_start = k_rise & ~write_port_sel_n & ~wr_act_q;
   assign rd_start = k_rise & ~read_port_sel_n;
   // active-low lane selects become a store mask
   assign lane_mask = ~byte_lane_enable_n;

   // ------------------------------------------------------------
   // write burst sequencer
   // ------------------------------------------------------------
   // word 0 lands with the select, words 1..3 follow
   always @*
   begin
      wr_act_d = wr_act_q;
      wr_beat_d = wr_beat_q;
      wr_addr_d = wr_addr_q;
      arr_we = {`BURST_LEN{1'b0}};
      arr_waddr = wr_addr_q;
      if (wr_start)
      begin
         // address taken only with the write select
         wr_addr_d = addr;
         arr_waddr = addr;
         arr_we = beat_onehot(`BEAT_FIRST);
         wr_act_d = 1'b1;
         wr_beat_d = `BEAT_SECOND;
      end
      else if (wr_act_q)
      begin
         // later words on consecutive edges, any phase
         arr_we = beat_onehot(wr_beat_q);
         wr_beat_d = wr_beat_q + 1'b1;
         if (wr_beat_q == `BEAT_LAST)
         begin
            // burst complete
            wr_act_d = 1'b0;
         end
      end
      // else: idle, write data and lanes ignored
   end

   // write state registers
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_act_q <= 1'b0;
         wr_beat_q <= `BEAT_FIRST;
         wr_addr_q <= {ADDR_W{1'b0}};
      end
      else
      begin
         wr_act_q <= wr_act_d;
         wr_beat_q <= wr_beat_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   // ------------------------------------------------------------
   // burst word arrays
   // ------------------------------------------------------------
   // one array per burst word, lanes sized by the variant:
   // x8 nibble lanes [3:0] [7:4], x18 [8:0] [17:9],
   // x36 adds [26:18] [35:27]
   genvar g;
   generate
      for (g = 0; g < `BURST_LEN; g = g + 1)
      begin : arr
         burst_word_mem
         #(
            .AW(ADDR_W),
            .DW(DATA_W),
            .NL(LANES)
         )
         u_mem
         (
            .core_clk(core_clk),
            .wr_en(arr_we[g]),
            .wr_addr(arr_waddr),
            .wr_lane(lane_mask),
            .wr_data(write_data),
            .rd_en(arr_re),
            .rd_addr(rd_addr_q),
            .rd_data(arr_rdata[g*DATA_W +: DATA_W])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // read sequencer
   // ------------------------------------------------------------
   // fetch all four words at once, then push in order
   always @*
   begin
      rd_st_d = rd_st_q;
      rd_beat_d = rd_beat_q;
      rd_addr_d = rd_addr_q;
      arr_re = 1'b0;
      buf_in_valid = 1'b0;
      // a new request sets pending, and wins over the take
      rd_pend_d = rd_pend_q;
      case (rd_st_q)
         RD_IDLE:
         begin
            // launch the fetch of a waiting request
            if (rd_pend_q)
            begin
               arr_re = 1'b1;
               rd_pend_d = 1'b0;
               rd_st_d = RD_FETCH;
            end
         end
         RD_FETCH:
         begin
            // array data appear one edge after the fetch
            rd_beat_d = `BEAT_FIRST;
            rd_st_d = RD_SEND;
         end
         RD_SEND:
         begin
            // push words 0..3, stall while buffer full
            buf_in_valid = 1'b1;
            if (buf_in_ready)
            begin
               rd_beat_d = rd_beat_q + 1'b1;
               if (rd_beat_q == `BEAT_LAST)
               begin
                  // a waiting request is fetched under the last push
                  arr_re = rd_pend_q;
                  rd_pend_d = 1'b0;
                  rd_st_d = rd_pend_q ? RD_SEND : RD_IDLE;
               end
            end
         end
         default:
         begin
            rd_st_d = RD_IDLE;
         end
      endcase
      if (rd_start && !rd_pend_d)
      begin
         // address taken only with the read select
         rd_pend_d = 1'b1;
         rd_addr_d = addr;
      end
   end

   // read state registers
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_st_q <= RD_IDLE;
         rd_beat_q <= `BEAT_FIRST;
         rd_pend_q <= 1'b0;
         rd_addr_q <= {ADDR_W{1'b0}};
      end
      else
      begin
         rd_st_q <= rd_st_d;
         rd_beat_q <= rd_beat_d;
         rd_pend_q <= rd_pend_d;
         rd_addr_q <= rd_addr_d;
      end
   end

   // word offered to the buffer
   assign buf_in_data = pick_word(arr_rdata, rd_beat_q);

   // ------------------------------------------------------------
   // read data buffer
   // ------------------------------------------------------------
   // a stalled output clock fills it and stalls the pushes
   read_skid_buffer
   #(
      .WIDTH(DATA_W),
      .DEPTH(`SKID_DEPTH),
      .PW(1)
   )
   u_buf
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(buf_out_valid),
      .out_ready(launch),
      .out_data(buf_out_data)
   );

   // ------------------------------------------------------------
   // output launch
   // ------------------------------------------------------------
   // output clock edges, or every input edge in single mode
   assign launch = single_clock_mode | out_clk_edge;

   // data, enable and strobe move only on launch edges
   always @*
   begin
      dout_d = dout_q;
      oe_d = oe_q;
      strobe_d = strobe_q;
      if (launch)
      begin
         // strobe runs on every launch edge, busy or not
         strobe_d = ~strobe_q;
         if (buf_out_valid)
         begin
            // next burst word onto the pins
            dout_d = buf_out_data;
            oe_d = 1'b1;
         end
         else if (rd_st_q == RD_IDLE && !rd_pend_q)
         begin
            // nothing left: release after this edge
            oe_d = 1'b0;
         end
         // else: words still on their way, hold
      end
   end

   // output registers
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dout_q <= {DATA_W{1'b0}};
         oe_q <= `OE_RESET;
         strobe_q <= `STROBE_RESET;
      end
      else
      begin
         dout_q <= dout_d;
         oe_q <= oe_d;
         strobe_q <= strobe_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign read_data_out = dout_q;
   assign read_data_oe = oe_q;
   assign return_strobe = strobe_q;

endmodule

// *** test/ddr_burst_sram_port_properties.sv ***
// concurrent checks on the burst sram port read side
`timescale 1ns/100ps
module ddr_burst_sram_port_chk
#(
   parameter ADDR_W = 18,
   parameter DATA_W = 36,
   parameter LANES = 4
)
(
   input wire core_clk,
   input wire rst_n,
   input wire k_rise,
   input wire [ADDR_W-1:0] addr,
   input wire read_port_sel_n,
   input wire write_port_sel_n,
   input wire [DATA_W-1:0] write_data,
   input wire [LANES-1:0] byte_lane_enable_n,
   input wire single_clock_mode,
   input wire out_clk_edge,
   input wire [DATA_W-1:0] read_data_out,
   input wire read_data_oe,
   input wire return_strobe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // read request on a true-phase edge
   sequence rd_req;
      k_rise && !read_port_sel_n;
   endsequence
   // an edge that launches a read word
   sequence launch;
      single_clock_mode || out_clk_edge;
   endsequence
   a_read_latency: assert property (
      rd_req ##0 single_clock_mode ##1 single_clock_mode[*4]
      |=> read_data_oe) else $error("read data not driven in time");
   a_burst_four: assert property (
      $rose(read_data_oe) && single_clock_mode |-> read_data_oe[*4])
      else $error("read burst shorter than four words");
   a_strobe_run: assert property (
      launch |=> return_strobe != $past(return_strobe))
      else $error("return strobe missed a launch edge");
   a_strobe_hold: assert property (
      !single_clock_mode && !out_clk_edge |=> $stable(return_strobe))
      else $error("return strobe moved without launch");
   a_data_hold: assert property (
      $stable(return_strobe) |-> $stable(read_data_out))
      else $error("read data moved without launch");
   a_oe_start: assert property (
      $rose(read_data_oe) |-> $changed(return_strobe))
      else $error("drive enable rose off a launch edge");
   a_oe_drop: assert property (
      $fell(read_data_oe) |-> $past(single_clock_mode || out_clk_edge))
      else $error("drive enable fell off a launch edge");
   a_oe_idle: assert property (
      (!read_data_oe && !(k_rise && !read_port_sel_n))[*8]
      |=> !read_data_oe) else $error("read data driven without request");
endmodule

bind ddr_burst_sram_port ddr_burst_sram_port_chk #(.ADDR_W(ADDR_W),
   .DATA_W(DATA_W), .LANES(LANES)) u_chk (.core_clk(core_clk),
   .rst_n(rst_n), .k_rise(k_rise), .addr(addr),
   .read_port_sel_n(read_port_sel_n), .write_port_sel_n(write_port_sel_n),
   .write_data(write_data), .byte_lane_enable_n(byte_lane_enable_n),
   .single_clock_mode(single_clock_mode), .out_clk_edge(out_clk_edge),
   .read_data_out(read_data_out), .read_data_oe(read_data_oe),
   .return_strobe(return_strobe));

// *** test/sram_ctrl_model.sv ***
// memory controller model driving address, selects and clock phases
`timescale 1ns/100ps
module sram_ctrl_model
(
   input wire core_clk,
   input wire stall,
   output reg k_rise,
   output reg [17:0] addr,
   output reg read_port_sel_n,
   output reg write_port_sel_n,
   output reg [35:0] write_data,
   output reg [3:0] byte_lane_enable_n,
   output reg out_clk_edge
);
   reg [1:0] div_q; // stall pattern counter
   initial
   begin
      k_rise = 1'b0;
      addr = 18'h00000;
      read_port_sel_n = 1'b1;
      write_port_sel_n = 1'b1;
      write_data = 36'h000000000;
      byte_lane_enable_n = 4'hf;
      out_clk_edge = 1'b1;
      div_q = 2'h0;
   end
   // phases alternate; output clock slowed when stalling
   always @(negedge core_clk)
   begin
      k_rise <= ~k_rise;
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      out_clk_edge <= !stall || (div_q == 2'h2);
   end
   // wait until the coming edge is a true-phase edge
   task wait_true;
      begin
         @(negedge core_clk);
         while (k_rise !== 1'b0)
            @(negedge core_clk);
      end
   endtask
   // four-word write; dry keeps the select high
   task wr(input [17:0] a, input [143:0] w, input [15:0] ln, input dry);
      integer i;
      begin
         wait_true;
         addr <= a;
         write_port_sel_n <= dry;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (i > 0)
               @(negedge core_clk);
            write_data <= w[i*36 +: 36];
            byte_lane_enable_n <= ln[i*4 +: 4];
            if (i == 1)
            begin
               write_port_sel_n <= 1'b1;
               addr <= ~a; // released bus shows garbage
            end
         end
         @(negedge core_clk);
         write_data <= ~w[108 +: 36];
         byte_lane_enable_n <= ~ln[12 +: 4];
      end
   endtask
   // read request on one true edge, address only then
   task rd(input [17:0] a);
      begin
         wait_true;
         addr <= a;
         read_port_sel_n <= 1'b0;
         @(negedge core_clk);
         addr <= ~a;
         read_port_sel_n <= 1'b1;
      end
   endtask
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the burst sram port
`timescale 1ns/100ps
module tb_top;
   reg core_clk; // set in the main sequence
   reg rst_n;
   reg single_clock_mode;
   reg stall; // slows the output clock
   wire k_rise, read_port_sel_n, write_port_sel_n, out_clk_edge;
   wire [17:0] addr;
   wire [35:0] write_data, read_data_out;
   wire [3:0] byte_lane_enable_n;
   wire read_data_oe, return_strobe;
   integer num_errors = 0;
   integer cmp_count = 0;
   reg [143:0] rb; // collected read burst
   reg [143:0] w1 = {36'h123456789, 36'hfedcba987, 36'h0f0f0f0f0,
      36'h5a5a5a5a5};
   // lane-masked second write over all ones, words 3..0
   reg [143:0] w2 = {36'h000000000, 36'hfffffffff, 36'hff803fe00,
      36'h007fc01ff};

   always #50 core_clk = ~core_clk;

   sram_ctrl_model u_ctrl (.core_clk(core_clk), .stall(stall),
      .k_rise(k_rise), .addr(addr), .read_port_sel_n(read_port_sel_n),
      .write_port_sel_n(write_port_sel_n), .write_data(write_data),
      .byte_lane_enable_n(byte_lane_enable_n), .out_clk_edge(out_clk_edge));
   ddr_burst_sram_port u_ddr_burst_sram_port (.core_clk(core_clk),
      .rst_n(rst_n), .k_rise(k_rise), .addr(addr),
      .read_port_sel_n(read_port_sel_n), .write_port_sel_n(write_port_sel_n),
      .write_data(write_data), .byte_lane_enable_n(byte_lane_enable_n),
      .single_clock_mode(single_clock_mode), .out_clk_edge(out_clk_edge),
      .read_data_out(read_data_out), .read_data_oe(read_data_oe),
      .return_strobe(return_strobe));

   // compare one value
   task chk(input [35:0] got, input [35:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // take four words, one per launch edge with drive enabled
   task get_burst;
      integer i, n;
      reg last;
      begin
         i = 0;
         n = 0;
         last = return_strobe;
         while (i < 4 && n < 60)
         begin
            @(posedge core_clk);
            #1;
            n = n + 1;
            if (return_strobe !== last && read_data_oe === 1'b1)
            begin
               rb[i*36 +: 36] = read_data_out;
               i = i + 1;
            end
            last = return_strobe;
         end
         chk(i, 4);
      end
   endtask
   // compare a burst word by word
   task chk_burst(input [143:0] exp);
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            chk(rb[i*36 +: 36], exp[i*36 +: 36]);
      end
   endtask
   // full write then read back, drive released after
   task t_write_read;
      begin
         u_ctrl.wr(18'h00a5c, w1, 16'h0000, 1'b0);
         u_ctrl.rd(18'h00a5c);
         get_burst;
         chk_burst(w1);
         repeat (3) @(posedge core_clk);
         #1;
         chk(read_data_oe, 1'b0);
      end
   endtask
   // lane masks per word keep old lanes
   task t_lanes;
      begin
         u_ctrl.wr(18'h3ffff, {4{36'hfffffffff}}, 16'h0000, 1'b0);
         u_ctrl.wr(18'h3ffff, 144'h0, 16'h0fa5, 1'b0);
         u_ctrl.rd(18'h3ffff);
         get_burst;
         chk_burst(w2);
      end
   endtask
   // write with select high changes nothing
   task t_deselect;
      begin
         u_ctrl.wr(18'h00a5c, 144'h0, 16'h0000, 1'b1);
         u_ctrl.rd(18'h00a5c);
         get_burst;
         chk_burst(w1);
      end
   endtask
   // reads on every other true edge run back to back
   task t_back_to_back;
      begin
         // collector runs alongside so no word of either burst is missed
         fork
            begin
               u_ctrl.rd(18'h3ffff);
               repeat (2) @(negedge core_clk);
               u_ctrl.rd(18'h00a5c);
            end
            begin
               get_burst;
               chk_burst(w2);
               get_burst;
               chk_burst(w1);
            end
         join
      end
   endtask
   // output clock slowed, no word lost
   task t_stall;
      begin
         @(negedge core_clk);
         single_clock_mode = 1'b0;
         stall = 1'b1;
         // let a slow launch edge release the previous burst first
         repeat (4) @(negedge core_clk);
         u_ctrl.rd(18'h00a5c);
         get_burst;
         chk_burst(w1);
         repeat (12) @(posedge core_clk);
         #1;
         chk(read_data_oe, 1'b0);
         @(negedge core_clk);
         stall = 1'b0;
         single_clock_mode = 1'b1;
      end
   endtask
   // print counts and verdict, then stop
   task report_and_stop;
      begin
         $display("compares %0d errors %0d", cmp_count, num_errors);
         if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask

   // watchdog against a hung handshake
   initial
   begin
      #(100 * 5000);
      num_errors = num_errors + 1;
      report_and_stop;
   end
   // main sequence
   initial
   begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      single_clock_mode = 1'b1;
      stall = 1'b0;
      repeat (20) @(negedge core_clk);
      chk(read_data_oe, 1'b0);
      chk(read_data_out, 36'h0);
      rst_n = 1'b1;
      t_write_read;
      t_lanes;
      t_deselect;
      t_back_to_back;
      t_stall;
      report_and_stop;
   end
endmodule
